// [common/pdio_regs.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef PDIO_REGS_SVH
`define PDIO_REGS_SVH
`define PDIO_CLK_HZ 25000000
`define PDIO_MIN_LOW_NS 30000
`define PDIO_MIN_LOW_CYC ((`PDIO_MIN_LOW_NS * 25 + 999) / 1000)
`define PDIO_ADDR_CFG1 8'h00
`define PDIO_ADDR_CFG2 8'h04
`define PDIO_ADDR_PER1 8'h08
`define PDIO_ADDR_DUTY1 8'h0C
`define PDIO_ADDR_PER2 8'h10
`define PDIO_ADDR_DUTY2 8'h14
`define PDIO_ADDR_STAT 8'h18
`define PDIO_ADDR_IRQ 8'h1C
`define PDIO_ADDR_MASK 8'h20
`define PDIO_CFG_MODE_LSB 0
`define PDIO_CFG_INV_BIT 2
`define PDIO_CFG_VAL_BIT 3
`define PDIO_CFG_RST 32'h00000000
`define PDIO_PER_RST 32'h000003E8
`define PDIO_DUTY_RST 32'h00000064
`define PDIO_IRQ_CLR_BIT 0
`define PDIO_IRQ_PULSE_BIT 1
`define PDIO_IRQ_IN1_BIT 2
`define PDIO_IRQ_IN2_BIT 3
`endif

// [common/pdio_pkg.sv]
// Types shared by the digital port pin logic
package pdio_pkg;
    typedef enum logic [1:0] {
        PDIO_MODE_SPECIAL,
        PDIO_MODE_INPUT,
        PDIO_MODE_OUTPUT,
        PDIO_MODE_PWM
    } pdio_mode_type;
endpackage

// [hdl/pdio_pwm.sv]
// PWM generator with programmable period and low time
module pdio_pwm (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [31:0] period,
    input wire logic [31:0] duty,
    output logic active
);
    logic [31:0] count;
    logic [31:0] next_count;
    logic next_active;

    always_comb begin
        next_count = count + 32'h00000001;
        if (count + 32'h00000001 >= period) begin
            next_count = 32'h00000000;
        end
        next_active = (next_count < duty);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            count <= 32'h00000000;
            active <= 1'b0;
        end else begin
            count <= next_count;
            active <= next_active;
        end
    end
endmodule

// [hdl/pdio_pulse_rx.sv]
// Measures low time of the incoming level and flags a valid pulse
`include "pdio_regs.svh"
module pdio_pulse_rx (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic active_low_seen,
    output logic pulse_valid
);
    localparam int MIN_CYC = `PDIO_MIN_LOW_CYC;
    logic [15:0] low_count;
    logic [15:0] next_low_count;
    logic next_pulse_valid;

    always_comb begin
        next_low_count = 16'h0000;
        next_pulse_valid = 1'b0;
        if (enable && active_low_seen) begin
            next_low_count = low_count;
            if (low_count < 16'(MIN_CYC)) begin
                next_low_count = low_count + 16'h0001;
            end
        end else if (enable && low_count >= 16'(MIN_CYC)) begin
            // Pulse counted on return to high, shorter lows dropped
            next_pulse_valid = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            low_count <= 16'h0000;
            pulse_valid <= 1'b0;
        end else begin
            low_count <= next_low_count;
            pulse_valid <= next_pulse_valid;
        end
    end
endmodule

// [hdl/pdio_top.sv]
// Digital port pins one and two with AXI4-Lite register access
// Notes on behaviour
// - Invert setting complements each pin's levels
// - Valid pulse on pin one clears protection
// - Pulse out when output turns on, unless protection is active
// - Pin one both receives and sends pulses
// - Static output true drives low level
// - Pulses go high, low, then high
// - Status pin high normally, low in protection
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`include "pdio_regs.svh"
module pdio_top (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic protection_active,
    input wire logic output_switch_on,
    output logic protection_clear,
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe,
    output logic irq
);
    import pdio_pkg::*;
    localparam int MIN_CYC = `PDIO_MIN_LOW_CYC;

    logic [31:0] cfg [2];
    logic [31:0] per [2];
    logic [31:0] duty [2];
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [7:0] awaddr_q;
    logic aw_held;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_held;
    logic [1:0] in_level;
    logic [1:0] in_level_d;
    logic [1:0] pwm_act;
    logic rx_valid;
    logic sw_d;
    logic [15:0] tx_count;
    logic [31:0] next_cfg [2];
    logic [31:0] next_per [2];
    logic [31:0] next_duty [2];
    logic [3:0] next_irq_stat;
    logic [3:0] next_irq_mask;
    logic [7:0] next_awaddr_q;
    logic next_aw_held;
    logic [31:0] next_wdata_q;
    logic [3:0] next_wstrb_q;
    logic next_w_held;
    logic next_bvalid;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic [1:0] next_bresp;
    logic [1:0] next_in_level;
    logic [15:0] next_tx_count;
    logic next_sw_d;
    logic next_protection_clear;
    logic [1:0] active;
    logic [1:0] next_pin_out;
    logic [1:0] next_pin_oe;
    logic do_write;
    logic clear_pulse;
    logic emit;

    function automatic pdio_mode_type mode_of(input logic [31:0] c);
        mode_of = pdio_mode_type'(c[`PDIO_CFG_MODE_LSB +: 2]);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] st);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                merge[8*b +: 8] = wd[8*b +: 8];
            end
        end
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pwm
            pdio_pwm u_pwm (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .period(per[gi]),
                .duty(duty[gi]),
                .active(pwm_act[gi])
            );
        end
    endgenerate

    pdio_pulse_rx u_rx (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .enable(mode_of(cfg[0]) == PDIO_MODE_SPECIAL && tx_count == 16'h0000),
        .active_low_seen(in_level[0]),
        .pulse_valid(rx_valid)
    );

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign irq = |(irq_stat & irq_mask);
    assign clear_pulse = rx_valid && protection_active;
    assign emit = output_switch_on && !sw_d && !protection_active;

    // Pin logic: active level is low at the pin under normal polarity
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            // Sampled level, true when pin is low (non inverted)
            next_in_level[p] = !pin_in[p] ^ cfg[p][`PDIO_CFG_INV_BIT];
            case (mode_of(cfg[p]))
                PDIO_MODE_SPECIAL: begin
                    if (p == 0) begin
                        active[p] = tx_count != 16'h0000;
                    end else begin
                        active[p] = protection_active;
                    end
                end
                PDIO_MODE_INPUT: active[p] = 1'b0;
                PDIO_MODE_OUTPUT: begin
                    active[p] = cfg[p][`PDIO_CFG_VAL_BIT];
                end
                PDIO_MODE_PWM: active[p] = pwm_act[p];
                default: active[p] = 1'b0;
            endcase
            next_pin_out[p] = !active[p] ^ cfg[p][`PDIO_CFG_INV_BIT];
            next_pin_oe[p] = mode_of(cfg[p]) != PDIO_MODE_INPUT;
        end
        // Pin one releases the line between emitted pulses to listen
        if (mode_of(cfg[0]) == PDIO_MODE_SPECIAL) begin
            next_pin_oe[0] = tx_count != 16'h0000;
        end
        next_sw_d = output_switch_on;
        next_protection_clear = clear_pulse;
        next_tx_count = tx_count;
        if (tx_count != 16'h0000) begin
            next_tx_count = tx_count - 16'h0001;
        end else if (emit && mode_of(cfg[0]) == PDIO_MODE_SPECIAL) begin
            next_tx_count = 16'(MIN_CYC) + 16'h0001;
        end
    end

    // Register file and AXI4-Lite handshakes
    always_comb begin
        next_cfg = cfg;
        next_per = per;
        next_duty = duty;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        next_awaddr_q = awaddr_q;
        next_aw_held = aw_held;
        next_wdata_q = wdata_q;
        next_wstrb_q = wstrb_q;
        next_w_held = w_held;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_awaddr_q = s_axi_awaddr;
            next_aw_held = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wdata_q = s_axi_wdata;
            next_wstrb_q = s_axi_wstrb;
            next_w_held = 1'b1;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = 2'h0;
            case (awaddr_q)
                `PDIO_ADDR_CFG1: next_cfg[0] = merge(cfg[0], wdata_q, wstrb_q);
                `PDIO_ADDR_CFG2: next_cfg[1] = merge(cfg[1], wdata_q, wstrb_q);
                `PDIO_ADDR_PER1: next_per[0] = merge(per[0], wdata_q, wstrb_q);
                `PDIO_ADDR_DUTY1: begin
                    next_duty[0] = merge(duty[0], wdata_q, wstrb_q);
                end
                `PDIO_ADDR_PER2: next_per[1] = merge(per[1], wdata_q, wstrb_q);
                `PDIO_ADDR_DUTY2: begin
                    next_duty[1] = merge(duty[1], wdata_q, wstrb_q);
                end
                `PDIO_ADDR_STAT: ;
                `PDIO_ADDR_IRQ: begin
                    if (wstrb_q[0]) begin
                        next_irq_stat = irq_stat & ~wdata_q[3:0];
                    end
                end
                `PDIO_ADDR_MASK: begin
                    if (wstrb_q[0]) begin
                        next_irq_mask = wdata_q[3:0];
                    end
                end
                default: next_bresp = 2'h2;
            endcase
        end
        // Events set after the clear so a coincident event wins
        if (clear_pulse) begin
            next_irq_stat[`PDIO_IRQ_CLR_BIT] = 1'b1;
        end
        if (tx_count == 16'h0000 && next_tx_count != 16'h0000) begin
            next_irq_stat[`PDIO_IRQ_PULSE_BIT] = 1'b1;
        end
        for (int p = 0; p < 2; p++) begin
            if (mode_of(cfg[p]) == PDIO_MODE_INPUT &&
                in_level[p] != in_level_d[p]) begin
                next_irq_stat[`PDIO_IRQ_IN1_BIT + p] = 1'b1;
            end
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = 2'h0;
            case (s_axi_araddr)
                `PDIO_ADDR_CFG1: next_rdata = cfg[0];
                `PDIO_ADDR_CFG2: next_rdata = cfg[1];
                `PDIO_ADDR_PER1: next_rdata = per[0];
                `PDIO_ADDR_DUTY1: next_rdata = duty[0];
                `PDIO_ADDR_PER2: next_rdata = per[1];
                `PDIO_ADDR_DUTY2: next_rdata = duty[1];
                `PDIO_ADDR_STAT: begin
                    next_rdata = {28'h0000000, protection_active,
                                  tx_count != 16'h0000, in_level};
                end
                `PDIO_ADDR_IRQ: next_rdata = {28'h0000000, irq_stat};
                `PDIO_ADDR_MASK: next_rdata = {28'h0000000, irq_mask};
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = 2'h2;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cfg[0] <= `PDIO_CFG_RST;
            cfg[1] <= `PDIO_CFG_RST;
            per[0] <= `PDIO_PER_RST;
            per[1] <= `PDIO_PER_RST;
            duty[0] <= `PDIO_DUTY_RST;
            duty[1] <= `PDIO_DUTY_RST;
            irq_stat <= 4'h0;
            irq_mask <= 4'h0;
            awaddr_q <= 8'h00;
            aw_held <= 1'b0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
            in_level <= 2'h0;
            in_level_d <= 2'h0;
            tx_count <= 16'h0000;
            sw_d <= 1'b0;
            protection_clear <= 1'b0;
            pin_out <= 2'h3;
            pin_oe <= 2'h0;
        end else begin
            cfg <= next_cfg;
            per <= next_per;
            duty <= next_duty;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            awaddr_q <= next_awaddr_q;
            aw_held <= next_aw_held;
            wdata_q <= next_wdata_q;
            wstrb_q <= next_wstrb_q;
            w_held <= next_w_held;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            in_level <= next_in_level;
            in_level_d <= in_level;
            tx_count <= next_tx_count;
            sw_d <= next_sw_d;
            protection_clear <= next_protection_clear;
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
        end
    end
endmodule

// [verification/pdio_monitor.sv]
// Concurrent checks on the digital port pin logic
`include "pdio_regs.svh"
module pdio_monitor (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic protection_active,
    input wire logic output_switch_on,
    input wire logic protection_clear,
    input wire logic [1:0] pin_in,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MIN_LOW = `PDIO_MIN_LOW_CYC;
    logic [10:0] low_in;
    logic [10:0] low_out;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    // Saturating lengths of the current low stretch, seen and driven
    always_ff @(posedge ref_clk) begin
        if (sys_rst || pin_in[0])
            low_in <= 11'h000;
        else if (low_in != 11'h7FF)
            low_in <= low_in + 11'h001;
        if (sys_rst || !pin_oe[0] || pin_out[0])
            low_out <= 11'h000;
        else if (low_out != 11'h7FF)
            low_out <= low_out + 11'h001;
    end
    a_reset_pins_idle: assert property ($fell(sys_rst) |->
        pin_oe == 2'b00 && pin_out == 2'b11 && !irq)
        else $error("pins not idle after reset");
    a_clear_one_cycle: assert property (protection_clear |=>
        !protection_clear) else $error("clear pulse too long");
    a_clear_needs_prot: assert property (protection_clear |->
        $past(protection_active)) else $error("clear without protection");
    a_clear_after_pulse: assert property ($rose(pin_in[0]) &&
        low_in >= MIN_LOW && !$past(pin_oe[0]) &&
        protection_active |-> ##[1:4] protection_clear)
        else $error("valid pulse gave no clear");
    a_short_ignored: assert property ($rose(pin_in[0]) &&
        low_in < MIN_LOW && !$past(pin_oe[0]) |->
        ##1 !protection_clear [*4]) else $error("short pulse cleared");
    a_emit_start: assert property ($rose(output_switch_on) &&
        !protection_active && !pin_oe[0] |->
        ##[1:4] (pin_oe[0] && !pin_out[0])) else $error("no pulse out");
    a_emit_width: assert property ($fell(pin_oe[0]) |->
        $past(low_out) >= MIN_LOW) else $error("emitted pulse too short");
    a_read_once: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid) else $error("read answered twice");
    a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
        s_axi_rdata == 32'h00000000) else $error("error read data not zero");
    c_clear: cover property (protection_clear);
    c_emit: cover property ($rose(pin_oe[0]));
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind pdio_top pdio_monitor u_pdio_monitor (.*);

// [verification/pdio_ext_model.sv]
// External instrument on pins one and two
module pdio_ext_model (
    input wire logic ref_clk,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe,
    output logic [1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pull_low = 2'b00;
    // Pull-up on each pin; the far end can only sink it low
    assign pin_in = (pin_out | ~pin_oe) & ~pull_low;
    task automatic drive(input int i, input logic v);
        @(posedge ref_clk);
        pull_low[i] <= v;
    endtask
    task automatic pulse(input int i, input int n);
        drive(i, 1'b1);
        repeat (n) @(posedge ref_clk);
        drive(i, 1'b0);
    endtask
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the digital port pin logic
`include "pdio_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq, protection_clear;
    logic protection_active = 0, output_switch_on = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr, pin_in, pin_out, pin_oe;
    logic [7:0] ra [4] = '{`PDIO_ADDR_CFG1, `PDIO_ADDR_PER1,
        `PDIO_ADDR_DUTY2, 8'h24};
    logic [31:0] rv [4] = '{`PDIO_CFG_RST, `PDIO_PER_RST,
        `PDIO_DUTY_RST, 32'h0};
    int mismatches = 0, n_checks = 0, cyc = 0, n_clr = 0, n, k, per, dut;
    int seed = 32'hf39c;
    pdio_top u_pdio_top (.*);
    pdio_ext_model u_pdio_ext_model (.ref_clk(ref_clk), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_in(pin_in));
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic tk(input int c);
        repeat (c) @(posedge ref_clk);
    endtask
    task automatic chk(input string s, input logic [31:0] e,
        input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask
    // Level at a driven pin for a given active state and invert setting
    function automatic logic exp_level(input logic act, input logic inv);
        return !act ^ inv;
    endfunction
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (protection_clear === 1'b1) n_clr++;
        if (cyc == 30000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        tk(20);
        sys_rst <= 1'b0;
        tk(1);
        chk("pin_out", 32'h3, pin_out);
        chk("pin_oe", 32'h0, pin_oe);
        for (k = 0; k < 4; k++) begin
            rdr(ra[k]);
            chk("reset_value", rv[k], rd);
            chk("rresp", (k == 3) ? 32'h2 : 32'h0, rr);
        end
        for (k = 0; k < 4; k++) begin
            if (k == 2) wr(`PDIO_ADDR_CFG2, 32'h4);
            protection_active <= k[0];
            tk(4);
            chk("status_pin", exp_level(k[0], k[1]), pin_out[1]);
        end
        wr(`PDIO_ADDR_CFG2, 32'h0);
        wr(`PDIO_ADDR_MASK, 32'h1);
        u_pdio_ext_model.pulse(0, 600);
        tk(10);
        chk("short_pulse", 32'h0, n_clr);
        u_pdio_ext_model.pulse(0, 750);
        tk(10);
        chk("clear_count", 32'h1, n_clr);
        chk("irq_clear", 32'h1, irq);
        wr(`PDIO_ADDR_IRQ, 32'h1);
        chk("irq_w1c", 32'h0, irq);
        protection_active <= 1'b0;
        tk(4);
        output_switch_on <= 1'b1;
        k = 0;
        while (pin_oe[0] !== 1'b1 && k < 8) begin
            tk(1);
            k++;
        end
        n = 0;
        while (pin_oe[0] === 1'b1 && pin_out[0] === 1'b0 && n < 2000) begin
            tk(1);
            n++;
        end
        chk("emit_start", 32'h1, k < 8);
        chk("emit_len", 32'h1, n >= `PDIO_MIN_LOW_CYC);
        tk(2);
        chk("emit_release", 32'h0, pin_oe[0]);
        for (k = 0; k < 4; k++) begin
            wr(`PDIO_ADDR_CFG2, {28'h0, k[1], k[0], 2'h2});
            tk(3);
            chk("static_out", exp_level(k[1], k[0]), pin_out[1]);
        end
        wr(`PDIO_ADDR_CFG2, 32'h1);
        wr(`PDIO_ADDR_MASK, 32'h0);
        u_pdio_ext_model.drive(1, 1'b1);
        tk(4);
        rdr(`PDIO_ADDR_STAT);
        chk("input_level", 32'h1, rd[1]);
        chk("irq_masked", 32'h0, irq);
        wr(`PDIO_ADDR_MASK, 32'h8);
        chk("irq_input", 32'h1, irq);
        wr(`PDIO_ADDR_IRQ, 32'h8);
        chk("irq_w1c", 32'h0, irq);
        u_pdio_ext_model.drive(1, 1'b0);
        wr(`PDIO_ADDR_CFG2, 32'h3);
        for (k = 0; k < 3; k++) begin
            per = 20 + ($random(seed) & 63);
            dut = 1 + (($random(seed) & 255) % (per - 1));
            wr(`PDIO_ADDR_PER2, per);
            wr(`PDIO_ADDR_DUTY2, dut);
            tk(2 * per);
            while (pin_out[1] !== 1'b1) tk(1);
            while (pin_out[1] !== 1'b0) tk(1);
            n = 0;
            repeat (4 * per) begin
                if (pin_out[1] === 1'b0) n++;
                tk(1);
            end
            chk("pwm_low", 4 * dut, n);
        end
        test_done();
    end
endmodule
